/* interrupt_accept_sequencer.v */
// Notes on behaviour
// - Entry takes exactly three machine cycles, stack save included.
// - Flag set during enable/disable: next instruction runs before entry.
// - Chained enable/disable: accept after the last plus one instruction.
// - Disable around the set cycle keeps request pending until enable.
// - Only global enable and disable are interrupt control instructions.
// - Flag set in last cycle: finish it, run one more, then entry.
// - Flag set earlier: entry right after the current instruction.
// - Instruction after the set is disable: request stays pending.
// - Software-set flag behaves exactly like a hardware-set flag.
// - Entry loads memory and register bank enables plus start address.
// - Reset disables all interrupts and sets status 0.
// - Service needs both source enable and master enable set.
// - Two low requests at once: higher default priority first, other held.
// - High and low together: high first, low stays pending.
// - Low during high service waits; then served in default order.
// - Accepting low moves status to 1, only designated high may nest.
// - Disabled source keeps its flag; service starts once enabled.
// - Routine may clear status to 0, letting enabled sources nest.
// - Status 0 all, 1 high only, 2 none; acceptance raises one level.
// - Status saved with the status word; return restores it.
// - Single enabled source on a vector: flag cleared on acceptance.
// - Both sharing sources enabled: OR requests, clear neither flag.
`include "intc_defines.vh"

module interrupt_accept_sequencer #(
    parameter CLK_PER_MC = `CLK_PER_MC
) (
    // clock and reset
    input  wire                     SYS_CLK,
    input  wire                     RST_N,
    // request sources
    input  wire [`N_SRC-1:0]        SRC_SET,
    // software access to flags and control bits
    input  wire [`N_SRC-1:0]        SW_SET_REQ,
    input  wire [`N_SRC-1:0]        SW_CLR_REQ,
    input  wire                     IE_WR,
    input  wire [`N_SRC-1:0]        IE_DATA,
    input  wire                     PSEL_WR,
    input  wire [3:0]               PSEL_DATA,
    input  wire                     ST_WR,
    input  wire [1:0]               ST_DATA,
    // instruction sequencer
    input  wire                     INSTR_LAST,
    input  wire                     INSTR_EI,
    input  wire                     INSTR_DI,
    input  wire                     RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC,
    input  wire [1:0]               POP_ST,
    input  wire [13:0]              VEC_DATA,
    // status and entry outputs
    output reg                      MC_TICK,
    output wire [`N_SRC-1:0]        REQ_FLAGS,
    output reg  [`N_SRC-1:0]        SRC_ENABLE,
    output reg                      MASTER_ENABLE,
    output reg  [`PSEL_CODE_W-1:0]  PRIORITY_SELECT,
    output reg  [1:0]               STATUS,
    output reg                      ENTRY_ACTIVE,
    output reg                      PUSH_PC_STB,
    output reg                      PUSH_PSW_STB,
    output reg  [1:0]               PUSH_ST,
    output reg  [1:0]               VEC_SEL,
    output reg                      VEC_LOAD_STB,
    output reg  [11:0]              PC_START,
    output reg                      MBE_OUT,
    output reg                      RBE_OUT
);

localparam DIV_W = 8;
localparam [DIV_W-1:0] DIV_LAST = CLK_PER_MC[DIV_W-1:0] - 8'h01;

reg  [DIV_W-1:0]  div_ff;
reg  [1:0]        state_ff;
reg  [1:0]        nxt_state;
reg  [`N_VEC-1:0] seen_ff;
reg  [1:0]        vec_ff;
reg  [`N_SRC-1:0] acc_clr;
reg  [`N_VEC-1:0] vreq;
reg  [1:0]        st_eff;
wire              mc_en;
wire              instr_end;
wire              ctrl_instr;
wire              pick_valid;
wire [1:0]        pick_index;
wire [`N_SRC-1:0] flags;
wire [`N_SRC-1:0] live;
wire              accept;

// ==========================================================================
// machine cycle enable
always @(posedge SYS_CLK) begin
    if (!RST_N) begin
        div_ff  <= 8'h00;
        MC_TICK <= 1'b0;
    end else begin
        MC_TICK <= (div_ff == DIV_LAST);
        if (div_ff == DIV_LAST) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end
end

assign mc_en      = MC_TICK;
assign instr_end  = mc_en & INSTR_LAST & (state_ff == `ENT_IDLE);
assign ctrl_instr = INSTR_EI | INSTR_DI;

// ==========================================================================
// request flags
request_flags #(
    .N       (`N_SRC)
) u_flags (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .hw_set  (SRC_SET),
    .sw_set  (SW_SET_REQ),
    .sw_clr  (SW_CLR_REQ),
    .acc_clr (acc_clr),
    .flag_ff (flags)
);

assign REQ_FLAGS = flags;

// ==========================================================================
// vector requests; a disabled source simply keeps its flag
assign live = flags & SRC_ENABLE;

always @* begin
    vreq    = {`N_VEC{1'b0}};
    vreq[0] = live[`SRC_BT] | live[`SRC_EXT4];
    vreq[1] = live[`SRC_EXT0];
    vreq[2] = live[`SRC_TMR0];
    vreq[3] = live[`SRC_SER];
    vreq    = vreq & {`N_VEC{MASTER_ENABLE}};
end

// ==========================================================================
// requests seen before the final machine cycle of an instruction
always @(posedge SYS_CLK) begin
    if (!RST_N) begin
        seen_ff <= {`N_VEC{1'b0}};
    end else if (mc_en) begin
        seen_ff <= vreq;
    end
end

// status that applies after the finishing instruction (return restores)
always @* begin
    st_eff = RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC ? POP_ST : STATUS;
end

priority_pick #(
    .NV      (`N_VEC)
) u_pick (
    .vreq    (seen_ff & vreq),
    .hi_code (PRIORITY_SELECT),
    .st      (st_eff),
    .valid   (pick_valid),
    .index   (pick_index)
);

// no acceptance at the end of an enable or disable instruction
assign accept = instr_end & pick_valid & ~ctrl_instr;

// ==========================================================================
// control bits
always @(posedge SYS_CLK) begin
    if (!RST_N) begin
        SRC_ENABLE      <= {`N_SRC{1'b0}};
        MASTER_ENABLE   <= 1'b0;
        PRIORITY_SELECT <= `PSEL_RESET;
    end else begin
        if (IE_WR) begin
            SRC_ENABLE <= IE_DATA;
        end
        if (PSEL_WR) begin
            PRIORITY_SELECT <= PSEL_DATA[`PSEL_CODE_W-1:0];
        end
        if (mc_en & INSTR_LAST & INSTR_DI) begin
            MASTER_ENABLE <= 1'b0;
        end else if (mc_en & INSTR_LAST & INSTR_EI) begin
            MASTER_ENABLE <= 1'b1;
        end else if (PSEL_WR & PSEL_DATA[`PSEL_ME_BIT]) begin
            MASTER_ENABLE <= 1'b1;
        end
    end
end

// ==========================================================================
// processing status
always @(posedge SYS_CLK) begin
    if (!RST_N) begin
        STATUS <= `ST_RESET;
    end else if (mc_en && state_ff == `ENT_PUSH_PSW) begin
        if (STATUS == `ST_LEVEL0) begin
            STATUS <= `ST_LEVEL1;
        end else begin
            STATUS <= `ST_LEVEL2;
        end
    end else if (mc_en & INSTR_LAST & RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC) begin
        STATUS <= POP_ST;
    end else if (ST_WR) begin
        STATUS <= ST_DATA;
    end
end

// ==========================================================================
// three-cycle entry sequencer
always @* begin
    nxt_state = state_ff;
    case (state_ff)
        `ENT_IDLE: begin
            if (accept) begin
                nxt_state = `ENT_PUSH_PC;
            end
        end
        `ENT_PUSH_PC: begin
            if (mc_en) begin
                nxt_state = `ENT_PUSH_PSW;
            end
        end
        `ENT_PUSH_PSW: begin
            if (mc_en) begin
                nxt_state = `ENT_LOAD_VEC;
            end
        end
        `ENT_LOAD_VEC: begin
            if (mc_en) begin
                nxt_state = `ENT_IDLE;
            end
        end
        default: begin
            nxt_state = `ENT_IDLE;
        end
    endcase
end

// flag clear during the status word push cycle
always @* begin
    acc_clr = {`N_SRC{1'b0}};
    if (mc_en && state_ff == `ENT_PUSH_PSW) begin
        case (vec_ff)
            2'h0: begin
                if (SRC_ENABLE[`SRC_BT] ^ SRC_ENABLE[`SRC_EXT4]) begin
                    acc_clr[`SRC_BT]   = SRC_ENABLE[`SRC_BT];
                    acc_clr[`SRC_EXT4] = SRC_ENABLE[`SRC_EXT4];
                end
            end
            2'h1: begin
                acc_clr[`SRC_EXT0] = 1'b1;
            end
            2'h2: begin
                acc_clr[`SRC_TMR0] = 1'b1;
            end
            2'h3: begin
                acc_clr[`SRC_SER] = 1'b1;
            end
            default: begin
                acc_clr = {`N_SRC{1'b0}};
            end
        endcase
    end
end

always @(posedge SYS_CLK) begin
    if (!RST_N) begin
        state_ff     <= `ENT_IDLE;
        vec_ff       <= 2'h0;
        ENTRY_ACTIVE <= 1'b0;
        PUSH_PC_STB  <= 1'b0;
        PUSH_PSW_STB <= 1'b0;
        PUSH_ST      <= `ST_RESET;
        VEC_SEL      <= 2'h0;
        VEC_LOAD_STB <= 1'b0;
        PC_START     <= 12'h000;
        MBE_OUT      <= 1'b0;
        RBE_OUT      <= 1'b0;
    end else begin
        state_ff     <= nxt_state;
        PUSH_PC_STB  <= 1'b0;
        PUSH_PSW_STB <= 1'b0;
        VEC_LOAD_STB <= 1'b0;
        if (accept) begin
            vec_ff       <= pick_index;
            VEC_SEL      <= pick_index;
            ENTRY_ACTIVE <= 1'b1;
        end
        if (mc_en) begin
            case (state_ff)
                `ENT_PUSH_PC: begin
                    PUSH_PC_STB <= 1'b1;
                end
                `ENT_PUSH_PSW: begin
                    PUSH_PSW_STB <= 1'b1;
                    PUSH_ST      <= STATUS;
                end
                `ENT_LOAD_VEC: begin
                    VEC_LOAD_STB <= 1'b1;
                    PC_START     <= VEC_DATA[`VW_ADDR_MSB:0];
                    MBE_OUT      <= VEC_DATA[`VW_MBE_BIT];
                    RBE_OUT      <= VEC_DATA[`VW_RBE_BIT];
                    ENTRY_ACTIVE <= 1'b0;
                end
                default: begin
                    PUSH_ST <= PUSH_ST;
                end
            endcase
        end
    end
end

endmodule // interrupt_accept_sequencer

/* intc_defines.vh */
`ifndef INTC_DEFINES_VH
`define INTC_DEFINES_VH

// ==========================================================================
// source and vector layout
`define N_SRC          5
`define N_VEC          4
`define SRC_BT         0
`define SRC_EXT4       1
`define SRC_EXT0       2
`define SRC_TMR0       3
`define SRC_SER        4

// ==========================================================================
// processing status codes held in the two status bits
`define ST_LEVEL0      2'h0
`define ST_LEVEL1      2'h1
`define ST_LEVEL2      2'h2
`define ST_RESET       2'h0

// ==========================================================================
// priority select write: bit 3 sets master enable, bits 2:0 pick the vector
`define PSEL_ME_BIT    3
`define PSEL_CODE_W    3
`define PSEL_RESET     3'h7

// ==========================================================================
// vector table word fields
`define VW_MBE_BIT     13
`define VW_RBE_BIT     12
`define VW_ADDR_MSB    11

// ==========================================================================
// data memory page of the interrupt control hardware
`define CTRL_PAGE      8'hfb

// ==========================================================================
// entry sequencer states
`define ENT_IDLE       2'h0
`define ENT_PUSH_PC    2'h1
`define ENT_PUSH_PSW   2'h2
`define ENT_LOAD_VEC   2'h3

// ==========================================================================
// machine cycle length in system clocks
`define CLK_PER_MC     4

`endif

/* request_flags.v */
`include "intc_defines.vh"

module request_flags #(
    parameter N = `N_SRC
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [N-1:0] hw_set,
    input  wire [N-1:0] sw_set,
    input  wire [N-1:0] sw_clr,
    input  wire [N-1:0] acc_clr,
    output reg  [N-1:0] flag_ff
);

// ==========================================================================
// one flag per source; a set always beats a clear in the same cycle
genvar i;
generate
    for (i = 0; i < N; i = i + 1) begin : g_flag
        always @(posedge clk) begin
            if (!rst_n) begin
                flag_ff[i] <= 1'b0;
            end else if (hw_set[i] | sw_set[i]) begin
                flag_ff[i] <= 1'b1;
            end else if (sw_clr[i] | acc_clr[i]) begin
                flag_ff[i] <= 1'b0;
            end
        end
    end
endgenerate

endmodule // request_flags

/* priority_pick.v */
`include "intc_defines.vh"

module priority_pick #(
    parameter NV = `N_VEC
) (
    input  wire [NV-1:0]             vreq,
    input  wire [`PSEL_CODE_W-1:0]   hi_code,
    input  wire [1:0]                st,
    output reg                       valid,
    output reg  [1:0]                index
);

reg hi_hit;
integer k;

// ==========================================================================
// designated high vector first, then lowest index among the rest
always @* begin
    valid  = 1'b0;
    index  = 2'h0;
    hi_hit = (hi_code < NV) && vreq[hi_code[1:0]]
             && (st != `ST_LEVEL2);
    if (hi_hit) begin
        valid = 1'b1;
        index = hi_code[1:0];
    end else if (st == `ST_LEVEL0) begin
        for (k = NV - 1; k >= 0; k = k - 1) begin
            if (vreq[k]) begin
                valid = 1'b1;
                index = k[1:0];
            end
        end
    end
end

endmodule // priority_pick

/* intc_props.sv */
// ==========================================
// entry sequence and acceptance checks
module intc_props #(
    parameter int CLK_PER_MC = 4
) (
    // clock and reset
    input wire logic        SYS_CLK, RST_N,
    // instruction sequencer
    input wire logic        MC_TICK, INSTR_LAST, INSTR_EI, INSTR_DI,
    input wire logic        RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC,
    input wire logic [1:0]  POP_ST,
    input wire logic [13:0] VEC_DATA,
    // state and entry outputs
    input wire logic        MASTER_ENABLE, ENTRY_ACTIVE, MBE_OUT, RBE_OUT,
    input wire logic        PUSH_PC_STB, PUSH_PSW_STB, VEC_LOAD_STB,
    input wire logic [4:0]  REQ_FLAGS,
    input wire logic [2:0]  PRIORITY_SELECT,
    input wire logic [1:0]  STATUS, PUSH_ST, VEC_SEL,
    input wire logic [11:0] PC_START
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    entry_timing_a: assert property (
        $rose(ENTRY_ACTIVE) |-> ##CLK_PER_MC PUSH_PC_STB
        ##CLK_PER_MC PUSH_PSW_STB ##CLK_PER_MC VEC_LOAD_STB)
        else $error("entry sequence length wrong");
    entry_end_a: assert property (
        VEC_LOAD_STB |-> !ENTRY_ACTIVE && $past(ENTRY_ACTIVE))
        else $error("entry did not end with vector load");
    master_gate_a: assert property (
        $rose(ENTRY_ACTIVE) |-> $past(MASTER_ENABLE))
        else $error("entry without master enable");
    status_gate_a: assert property (
        $rose(ENTRY_ACTIVE) |-> $past(RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC ? POP_ST : STATUS) != 2'h2)
        else $error("entry taken in status 2");
    high_only_a: assert property (
        $rose(ENTRY_ACTIVE) && $past(RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC ? POP_ST : STATUS) == 2'h1
        |-> $past(PRIORITY_SELECT) == {1'b0, VEC_SEL})
        else $error("low source nested in status 1");
    control_refuse_a: assert property (
        MC_TICK && INSTR_LAST && (INSTR_EI || INSTR_DI) |=> !ENTRY_ACTIVE)
        else $error("entry after enable or disable instruction");
    disable_clear_a: assert property (
        MC_TICK && INSTR_LAST && INSTR_DI |=> !MASTER_ENABLE)
        else $error("master enable kept after disable");
    status_push_a: assert property (
        PUSH_PSW_STB |-> PUSH_ST == $past(STATUS)
        && STATUS == PUSH_ST + 2'h1)
        else $error("status not saved and raised");
    return_pop_a: assert property (
        MC_TICK && INSTR_LAST && RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC |=> STATUS == $past(POP_ST))
        else $error("status not restored on return");
    vector_word_a: assert property (
        VEC_LOAD_STB |-> {MBE_OUT, RBE_OUT, PC_START} == $past(VEC_DATA))
        else $error("vector word not loaded");
    auto_clear_a: assert property (
        PUSH_PSW_STB && VEC_SEL != 2'h0 |-> !REQ_FLAGS[VEC_SEL + 3'h1])
        else $error("request flag not cleared on entry");
endmodule // intc_props

bind interrupt_accept_sequencer intc_props #(.CLK_PER_MC(CLK_PER_MC))
    props (.*);

/* core_model.sv */
// ==========================================
// core sequencer: two-cycle instructions and a status stack
module core_model (
    input  logic        clk, rst_n, tick, entry, psw_stb,
    input  logic [1:0]  push_st, sel, op,
    output logic        last, ei, di, return_from_interrupt_instruction,
    output logic [1:0]  pop_st,
    output logic [13:0] vec
);
    logic [1:0] kind_ff, sp_ff;
    logic       cnt_ff;
    logic [1:0] stack_ff [4];
    // no last cycle is shown while entry runs
    assign last = cnt_ff && !entry;
    assign ei = kind_ff == 2'h1;
    assign di = kind_ff == 2'h2;
    assign return_from_interrupt_instruction = kind_ff == 2'h3;
    assign pop_st = stack_ff[sp_ff - 2'h1];
    assign vec = {sel, 8'h10, 2'h0, sel};
    always @(posedge clk) begin
        if (!rst_n) begin
            kind_ff <= 2'h0;
            sp_ff <= 2'h0;
            cnt_ff <= 1'b0;
        end else begin
            if (psw_stb) begin
                stack_ff[sp_ff] <= push_st;
                sp_ff <= sp_ff + 2'h1;
            end
            if (tick && !entry) begin
                cnt_ff <= !cnt_ff;
                if (cnt_ff) begin
                    kind_ff <= op;
                    if (return_from_interrupt_instruction) sp_ff <= sp_ff - 2'h1;
                end
            end
        end
    end
endmodule // core_model

/* tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        SYS_CLK = 1'b0, RST_N = 1'b0;
    logic [4:0]  SRC_SET = 5'h00, SW_SET_REQ = 5'h00, SW_CLR_REQ = 5'h00;
    logic [4:0]  IE_DATA = 5'h00, REQ_FLAGS, SRC_ENABLE;
    logic        IE_WR = 1'b0, PSEL_WR = 1'b0, ST_WR = 1'b0;
    logic [3:0]  PSEL_DATA = 4'h0;
    logic [1:0]  ST_DATA = 2'h0, op = 2'h0, POP_ST, PUSH_ST, VEC_SEL, STATUS;
    logic [2:0]  PRIORITY_SELECT;
    logic [11:0] PC_START;
    logic [13:0] VEC_DATA;
    logic        INSTR_LAST, INSTR_EI, INSTR_DI, RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC, MC_TICK;
    logic        MASTER_ENABLE, ENTRY_ACTIVE, PUSH_PC_STB, PUSH_PSW_STB;
    logic        VEC_LOAD_STB, MBE_OUT, RBE_OUT;
    logic [1:0]  got [$];
    int          miscompares = 0, comparisons = 0;

    interrupt_accept_sequencer dut (.*);
    core_model core (
        .clk(SYS_CLK), .rst_n(RST_N), .tick(MC_TICK), .entry(ENTRY_ACTIVE),
        .psw_stb(PUSH_PSW_STB), .push_st(PUSH_ST), .sel(VEC_SEL), .op(op),
        .last(INSTR_LAST), .ei(INSTR_EI), .di(INSTR_DI), .return_from_interrupt_instruction(RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC),
        .pop_st(POP_ST), .vec(VEC_DATA)
    );

    always #50 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) if (VEC_LOAD_STB) got.push_back(VEC_SEL);

    // ==========================================
    // helpers
    task automatic chk(input string n, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick;
        @(posedge SYS_CLK);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick;
        s = 1'b0;
    endtask
    task automatic src(input logic [4:0] m);
        SRC_SET = m;
        tick;
        SRC_SET = 5'h00;
    endtask
    task automatic en(input logic [4:0] m);
        IE_DATA = m;
        pulse(IE_WR);
    endtask
    task automatic psel(input logic [3:0] d);
        PSEL_DATA = d;
        pulse(PSEL_WR);
    endtask
    // op is taken when the running instruction ends
    task automatic ins(input logic [1:0] k);
        if (op != k) op = k;
        @(posedge SYS_CLK iff (MC_TICK && INSTR_LAST));
        #1;
        if (op != 2'h0) op = 2'h0;
    endtask
    task automatic run(input int n);
        repeat (n) ins(2'h0);
    endtask
    task automatic order(input int n, input logic [7:0] e);
        logic [7:0] v = 8'h00;
        foreach (got[i]) v = {v[5:0], got[i]};
        chk("entries", got.size(), n);
        chk("vectors", v, e);
        got.delete();
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset;
        chk("status", STATUS, 2'h0);
        chk("master", MASTER_ENABLE, 1'b0);
        chk("prio", PRIORITY_SELECT, 3'h7);
        chk("flags", REQ_FLAGS, 5'h00);
        $display("done reset");
    endtask
    task automatic t_hold;
        en(5'h08);
        SW_SET_REQ = 5'h08;
        tick;
        SW_SET_REQ = 5'h00;
        run(3);
        chk("held", REQ_FLAGS, 5'h08);
        chk("ie", SRC_ENABLE, 5'h08);
        order(0, 8'h00);
        psel(4'hf);
        run(3);
        order(1, 8'h02);
        chk("clr", REQ_FLAGS, 5'h00);
        chk("st1", STATUS, 2'h1);
        chk("word", {MBE_OUT, RBE_OUT, PC_START}, 14'h2102);
        ins(2'h3);
        run(1);
        chk("st0", STATUS, 2'h0);
        $display("done hold");
    endtask
    task automatic t_pair;
        en(5'h0c);
        run(1);
        src(5'h0c);
        ins(2'h0);
        tick;
        chk("early", ENTRY_ACTIVE, 1'b1);
        run(3);
        ins(2'h3);
        run(3);
        order(2, 8'h06);
        ins(2'h3);
        run(1);
        chk("st", STATUS, 2'h0);
        $display("done pair");
    endtask
    task automatic t_high;
        en(5'h1c);
        psel(4'hb);
        src(5'h18);
        run(3);
        order(1, 8'h03);
        src(5'h04);
        run(3);
        order(0, 8'h00);
        repeat (3) begin
            ins(2'h3);
            run(3);
        end
        order(2, 8'h06);
        src(5'h08);
        run(3);
        src(5'h10);
        run(3);
        order(2, 8'h0b);
        chk("lvl2", STATUS, 2'h2);
        repeat (2) begin
            ins(2'h3);
            run(1);
        end
        chk("back", STATUS, 2'h0);
        $display("done high");
    endtask
    task automatic t_di;
        en(5'h04);
        ins(2'h2);
        src(5'h04);
        run(3);
        chk("pend", REQ_FLAGS, 5'h04);
        chk("me", MASTER_ENABLE, 1'b0);
        order(0, 8'h00);
        ins(2'h1);
        run(2);
        tick;
        chk("late", ENTRY_ACTIVE, 1'b1);
        run(3);
        order(1, 8'h01);
        ins(2'h3);
        run(1);
        $display("done disable");
    endtask
    task automatic t_share;
        en(5'h03);
        src(5'h03);
        run(3);
        order(1, 8'h00);
        chk("both", REQ_FLAGS, 5'h03);
        SW_CLR_REQ = 5'h03;
        tick;
        SW_CLR_REQ = 5'h00;
        ins(2'h3);
        run(1);
        en(5'h02);
        src(5'h02);
        run(3);
        order(1, 8'h00);
        chk("one", REQ_FLAGS, 5'h00);
        ins(2'h3);
        run(1);
        $display("done share");
    endtask
    task automatic t_nest;
        en(5'h0c);
        run(1);
        repeat (5) tick;
        src(5'h08);
        ins(2'h0);
        tick;
        chk("wait", ENTRY_ACTIVE, 1'b0);
        ins(2'h0);
        tick;
        chk("go", ENTRY_ACTIVE, 1'b1);
        run(3);
        src(5'h04);
        run(3);
        order(1, 8'h02);
        pulse(ST_WR);
        run(3);
        order(1, 8'h01);
        chk("lvl", STATUS, 2'h1);
        ins(2'h3);
        run(1);
        ins(2'h3);
        run(1);
        chk("st", STATUS, 2'h0);
        $display("done nest");
    endtask

    initial begin
        repeat (6) @(posedge SYS_CLK);
        #1 RST_N = 1'b1;
        t_reset;
        t_hold;
        t_pair;
        t_high;
        t_di;
        t_share;
        t_nest;
        tally_and_finish;
    end
    initial begin
        #3000000;
        miscompares++;
        tally_and_finish;
    end
endmodule // tb
